//--- src/asps_defines.svh
// Constants of the converter serial port sequencer
`ifndef ASPS_DEFINES_SVH
`define ASPS_DEFINES_SVH
`define ASPS_CMD_BITS      4'h8
`define ASPS_RESET_ONES    6'h20
`define ASPS_REG16_BITS    5'h10
`define ASPS_REG8_BITS     5'h08
`define ASPS_DATA_BITS     5'h18
`define ASPS_CMD_RW_BIT    6
`define ASPS_CMD_RS_HI     5
`define ASPS_CMD_RS_LO     3
`define ASPS_RS_STATUS     3'h0
`define ASPS_RS_MODE       3'h1
`define ASPS_RS_CONFIG     3'h2
`define ASPS_RS_DATA       3'h3
`define ASPS_MODE_RESET    16'h000a
`define ASPS_CONFIG_RESET  16'h0710
`define ASPS_CFG_CH_MASK   16'h000f
`define ASPS_CFG_CH_HI     3
`define ASPS_CFG_CH_LO     0
`endif

//--- src/asps_pkg.sv
// Types of the converter serial port sequencer
package asps_pkg;
    typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} asps_phase_type;
    typedef struct packed {
        logic [1:0]     cs_s;
        logic [1:0]     sclk_s;
        logic [1:0]     din_s;
        logic           cs_d;
        logic           sclk_d;
        asps_phase_type phase;
        logic [4:0]     cnt;
        logic [5:0]     ones;
        logic [7:0]     cmd;
        logic [23:0]    sh;
        logic [15:0]    mode;
        logic [15:0]    config_v;
        logic [23:0]    data;
        logic           rdy_n;
        logic           dout;
        logic           dout_oe;
        logic           wr_stb;
    } asps_state_type;
endpackage : asps_pkg

//--- src/asps_top.sv
// Serial port sequencer of a sigma-delta converter, device side
//
// Summary of operation
// - Select tied low gives three-wire operation
// - Select falling edge presents first output bit
// - Clocks ignored while not selected
// - Thirty-two ones reset port, mode and configuration registers
// - Sixteen-bit register takes exactly sixteen clocks
// - Return to command wait after count
// - Ones discarded; zero gates seven command bits
// - Select high disables port entirely
// - Command 0x10 writes configuration register
// - Command 0x58 reads 24-bit data
// - Configuration 0x0010/0x0011 select input pairs
// - Stray clock with data-in low gates command
// - Ready falls on new result, rises on data read
`timescale 1ns/1ps
`default_nettype none
`include "asps_defines.svh"
module asps_top
    import asps_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        CS_B,
    input  wire logic        SCLK,
    input  wire logic        DIN,
    input  wire logic        CONV_VALID,
    input  wire logic [23:0] CONV_DATA,
    input  wire logic        CONV_UPDATE,
    output logic             DOUT,
    output logic             DOUT_OE,
    output logic [15:0]      MODE_REG,
    output logic [15:0]      CONFIG_REG,
    output logic [3:0]       CHANNEL_SEL,
    output logic             REG_WR_STB
);
    import asps_pkg::*;

    asps_state_type st_r;
    asps_state_type st_nxt;

    logic sel;
    logic rise;
    logic fall;
    logic cs_fall;
    logic bit_in;
    logic [2:0] rs;
    logic [4:0] len;

    // ****************************************************************
    // Pin views and serial clock edges
    // ****************************************************************
    // Pins pass two flops, so edges lag the pins by about two cycles
    always_comb begin
        // select held low keeps port live
        sel     = ~st_r.cs_s[1];
        rise    = st_r.sclk_s[1] & ~st_r.sclk_d;
        fall    = ~st_r.sclk_s[1] & st_r.sclk_d;
        cs_fall = st_r.cs_d & ~st_r.cs_s[1];
        bit_in  = st_r.din_s[1];
        rs      = st_r.cmd[`ASPS_CMD_RS_HI:`ASPS_CMD_RS_LO];
        len     = (rs == `ASPS_RS_DATA) ? `ASPS_DATA_BITS :
                  (rs == `ASPS_RS_STATUS) ? `ASPS_REG8_BITS : `ASPS_REG16_BITS;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt        = st_r;
        st_nxt.cs_s   = {st_r.cs_s[0], CS_B};
        st_nxt.sclk_s = {st_r.sclk_s[0], SCLK};
        st_nxt.din_s  = {st_r.din_s[0], DIN};
        st_nxt.cs_d   = st_r.cs_s[1];
        st_nxt.sclk_d = st_r.sclk_s[1];
        // Strobe lasts one cycle
        st_nxt.wr_stb = 1'b0;
        // Update request wins over a new result
        // ready handling
        if (CONV_UPDATE) begin
            st_nxt.rdy_n = 1'b1;
        end else if (CONV_VALID) begin
            st_nxt.data  = CONV_DATA;
            st_nxt.rdy_n = 1'b0;
        end
        st_nxt.dout_oe = sel;
        if (st_r.phase != ST_READ) begin
            st_nxt.dout = st_nxt.rdy_n;
        end
        if (sel) begin
            if (cs_fall && st_r.phase == ST_READ) begin
                st_nxt.dout = st_r.sh[23];
            end
            if (rise) begin
                // Count saturates, so a longer run keeps resetting
                // ones reset
                if (bit_in) begin
                    st_nxt.ones = (st_r.ones == `ASPS_RESET_ONES) ? st_r.ones
                                : st_r.ones + 6'h01;
                end else begin
                    st_nxt.ones = 6'h00;
                end
                case (st_r.phase)
                    ST_CMD: begin
                        if (st_r.cnt != 5'h00 || !bit_in) begin
                            st_nxt.cmd = {st_r.cmd[6:0], bit_in};
                            st_nxt.cnt = st_r.cnt + 5'h01;
                        end
                        if (st_r.cnt == 5'(`ASPS_CMD_BITS - 4'h1)) begin
                            st_nxt.cnt = 5'h00;
                            if (st_nxt.cmd[`ASPS_CMD_RW_BIT]) begin
                                st_nxt.phase = ST_READ;
                                case (st_nxt.cmd[`ASPS_CMD_RS_HI:`ASPS_CMD_RS_LO])
                                    `ASPS_RS_MODE:   st_nxt.sh = {st_r.mode, 8'h00};
                                    `ASPS_RS_CONFIG: st_nxt.sh = {st_r.config_v, 8'h00};
                                    `ASPS_RS_DATA:   st_nxt.sh = st_r.data;
                                    // Status read carries ready in its lowest bit
                                    default:         st_nxt.sh = {7'h00, st_r.rdy_n, 16'h0000};
                                endcase
                            end else begin
                                st_nxt.phase = ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        st_nxt.sh  = {st_r.sh[22:0], bit_in};
                        st_nxt.cnt = st_r.cnt + 5'h01;
                        // Stray clocks mid-transfer still shift the count
                        // exact register length: sixteen clocks for mode and configuration
                        if (st_r.cnt == len - 5'h01) begin
                            st_nxt.phase  = ST_CMD;
                            st_nxt.cnt    = 5'h00;
                            st_nxt.wr_stb = 1'b1;
                            if (rs == `ASPS_RS_CONFIG) begin
                                st_nxt.config_v = st_nxt.sh[15:0];
                            end else if (rs == `ASPS_RS_MODE) begin
                                st_nxt.mode = st_nxt.sh[15:0];
                            end
                        end
                    end
                    ST_READ: begin
                        st_nxt.sh  = {st_r.sh[22:0], 1'b0};
                        st_nxt.cnt = st_r.cnt + 5'h01;
                        if (st_r.cnt == len - 5'h01) begin
                            st_nxt.phase = ST_CMD;
                            st_nxt.cnt   = 5'h00;
                            // New result on the same edge keeps ready low
                            // ready rises after read
                            if (rs == `ASPS_RS_DATA && !CONV_VALID) begin
                                st_nxt.rdy_n = 1'b1;
                            end
                            // Last rise hands the pin back to ready
                            st_nxt.dout = st_nxt.rdy_n;
                        end
                    end
                    default: st_nxt.phase = ST_CMD;
                endcase
                // Ones reset overrides a write ending on this edge
                // thirty-two ones restore defaults
                if (st_nxt.ones == `ASPS_RESET_ONES) begin
                    st_nxt.phase    = ST_CMD;
                    st_nxt.cnt      = 5'h00;
                    st_nxt.mode     = `ASPS_MODE_RESET;
                    st_nxt.config_v = `ASPS_CONFIG_RESET;
                    st_nxt.wr_stb   = 1'b0;
                end
            end
            // Output bits follow the falling edge
            if (fall && st_r.phase == ST_READ) begin
                st_nxt.dout = st_r.sh[23];
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r          <= '0;
            st_r.cs_s     <= 2'h3;
            st_r.sclk_s   <= 2'h3;
            st_r.din_s    <= 2'h3;
            st_r.cs_d     <= 1'b1;
            st_r.sclk_d   <= 1'b1;
            st_r.phase    <= ST_CMD;
            st_r.mode     <= `ASPS_MODE_RESET;
            st_r.config_v <= `ASPS_CONFIG_RESET;
            st_r.rdy_n    <= 1'b1;
            st_r.dout     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // channel field of configuration
    assign DOUT        = st_r.dout;
    assign DOUT_OE     = st_r.dout_oe;
    assign MODE_REG    = st_r.mode;
    assign CONFIG_REG  = st_r.config_v;
    assign CHANNEL_SEL = st_r.config_v[`ASPS_CFG_CH_HI:`ASPS_CFG_CH_LO];
    assign REG_WR_STB  = st_r.wr_stb;
endmodule : asps_top
`default_nettype wire

//--- verif/asps_checker.sv
// Port assertions of the serial port sequencer
`timescale 1ns/1ps
`default_nettype none
module asps_checker (
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        CS_B,
    input wire logic        CONV_VALID,
    input wire logic        DOUT,
    input wire logic        DOUT_OE,
    input wire logic [15:0] MODE_REG,
    input wire logic [15:0] CONFIG_REG,
    input wire logic [3:0]  CHANNEL_SEL,
    input wire logic        REG_WR_STB
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_chan_follows_cfg: assert property (CHANNEL_SEL == CONFIG_REG[3:0])
        else $error("channel select differs from config");
    a_reset_values: assert property ($rose(RST_B) |->
        MODE_REG == 16'h000a && CONFIG_REG == 16'h0710) else $error("register reset value wrong");
    a_cfg_by_write: assert property ($changed(CONFIG_REG) |->
        REG_WR_STB || CONFIG_REG == 16'h0710) else $error("config changed without a write");
    a_mode_by_write: assert property ($changed(MODE_REG) |->
        REG_WR_STB || MODE_REG == 16'h000a) else $error("mode changed without a write");
    a_oe_when_sel: assert property ((!CS_B)[*5] |-> DOUT_OE)
        else $error("output not driven while selected");
    a_oe_off_desel: assert property (CS_B[*5] |-> !DOUT_OE)
        else $error("output driven while deselected");
    a_hold_desel: assert property (CS_B[*5] |=> $stable(MODE_REG) && $stable(CONFIG_REG))
        else $error("register changed while deselected");
    a_stb_single: assert property (REG_WR_STB |=> !REG_WR_STB)
        else $error("write strobe longer than one cycle");
    a_stb_selected: assert property (REG_WR_STB |-> !$past(CS_B, 2))
        else $error("write strobe while deselected");
    a_oe_fall_cause: assert property ($fell(DOUT_OE) |-> $past(CS_B, 2))
        else $error("output enable fell without deselect");
    c_write: cover property (REG_WR_STB);
    c_ready: cover property (CONV_VALID ##[1:8] !DOUT);
    c_desel: cover property ($fell(DOUT_OE));
endmodule : asps_checker
bind asps_top asps_checker i_chk (.CLK(CLK), .RST_B(RST_B), .CS_B(CS_B),
    .CONV_VALID(CONV_VALID), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .MODE_REG(MODE_REG),
    .CONFIG_REG(CONFIG_REG), .CHANNEL_SEL(CHANNEL_SEL), .REG_WR_STB(REG_WR_STB));
`default_nettype wire

//--- verif/asps_host.sv
// Serial host model driving the converter port
`timescale 1ns/1ps
`default_nettype none
module asps_host (
    input  wire logic CLK,
    input  wire logic DOUT,
    output var logic  CS_B,
    output var logic  SCLK,
    output var logic  DIN
);
    initial begin
        CS_B = 1'b1;
        SCLK = 1'b1;
        DIN  = 1'b1;
    end
    task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] rd);
        rd = '0;
        @(posedge CLK);
        for (int i = n - 1; i >= 0; i--) begin
            SCLK <= 1'b0;
            DIN  <= v[i];
            repeat (4) @(posedge CLK);
            // Sample while low: the last rise hands the pin back to ready
            rd = {rd[30:0], DOUT};
            SCLK <= 1'b1;
            repeat (4) @(posedge CLK);
        end
        DIN <= 1'b1;
    endtask : xfer
    task automatic sel(input logic v);
        @(posedge CLK);
        CS_B <= v;
        repeat (8) @(posedge CLK);
    endtask : sel
    // poll ready low before a data read
    task automatic wait_rdy(input int limit, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < limit && !ok; i++) begin
            @(posedge CLK);
            ok = !DOUT;
        end
    endtask : wait_rdy
endmodule : asps_host
`default_nettype wire

//--- verif/asps_top_tb.sv
// Self-checking bench of the serial port sequencer
`timescale 1ns/1ps
`default_nettype none
module asps_top_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cs_b, sclk, din, dout, dout_oe, stb;
    logic        conv_valid = 1'b0;
    logic        conv_update = 1'b0;
    logic [23:0] conv_data = 24'h000000;
    logic [15:0] mode_reg, config_reg;
    logic [3:0]  channel_sel;
    logic [31:0] rd;
    logic        ok;
    logic        dout_line;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          stbs = 0;
    always #2 clk = ~clk;
    // Released line reads as the inverse of the DUT output register, which keeps following ready
    assign dout_line = dout_oe ? dout : ~dout;
    asps_host i_host (.CLK(clk), .DOUT(dout_line), .CS_B(cs_b), .SCLK(sclk), .DIN(din));
    asps_top i_dut (.CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .DIN(din),
        .CONV_VALID(conv_valid), .CONV_DATA(conv_data), .CONV_UPDATE(conv_update),
        .DOUT(dout), .DOUT_OE(dout_oe), .MODE_REG(mode_reg), .CONFIG_REG(config_reg),
        .CHANNEL_SEL(channel_sel), .REG_WR_STB(stb));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_host.xfer(8, {24'h000000, c}, rd);
        i_host.xfer(16, {16'h0000, d}, rd);
        repeat (4) @(posedge clk);
    endtask : wr
    task automatic conv(input logic u);
        conv_update <= u;
        conv_valid  <= ~u;
        @(posedge clk);
        conv_update <= 1'b0;
        conv_valid  <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : conv
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Ceiling well above the roughly two thousand cycles needed
    always @(posedge clk) begin
        cycles++;
        if (stb === 1'b1)
            stbs++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk(24'(mode_reg), 24'h00000a);
        chk(24'(config_reg), 24'h000710);
        i_host.sel(1'b0);
        i_host.xfer(32, 32'hffffffff, rd);
        i_host.xfer(8, 32'h000000ff, rd);
        wr(8'h08, 16'h1234);
        chk(24'(mode_reg), 24'h001234);
        wr(8'h10, 16'h0011);
        chk(24'(config_reg), 24'h000011);
        chk(24'(channel_sel), 24'h000001);
        wr(8'h10, 16'h0010);
        chk(24'(channel_sel), 24'h000000);
        i_host.sel(1'b1);
        wr(8'h10, 16'h0013);
        chk(24'(config_reg), 24'h000010);
        i_host.sel(1'b0);
        conv_data <= 24'ha5c3e1;
        conv(1'b0);
        chk(24'(dout), 24'h000000);
        i_host.wait_rdy(64, ok);
        chk(24'(ok), 24'h000001);
        i_host.xfer(8, 32'h00000058, rd);
        // Frame the data read by select: first bit follows its fall
        i_host.sel(1'b1);
        i_host.sel(1'b0);
        chk(24'(dout), 24'h000001);
        i_host.xfer(24, 32'h00ffffff, rd);
        chk(rd[23:0], 24'ha5c3e1);
        repeat (4) @(posedge clk);
        chk(24'(dout), 24'h000001);
        conv(1'b0);
        conv(1'b1);
        chk(24'(dout), 24'h000001);
        i_host.xfer(1, 32'h00000000, rd);
        wr(8'h10, 16'h0011);
        chk(24'(mode_reg), 24'h000008);
        chk(24'(stbs), 24'h000004);
        i_host.xfer(32, 32'hffffffff, rd);
        repeat (4) @(posedge clk);
        chk(24'(mode_reg), 24'h00000a);
        chk(24'(config_reg), 24'h000710);
        conclude();
    end
endmodule : asps_top_tb
`default_nettype wire
